// ==== logic/uart_status_flags.sv ====
// Summary of operation
// - tx fifo four or fewer, enabled: flag, dma
// - tx flag clear at five or disabled
// - tx interrupt only with tx irq enable
// - rx fifo five or more, enabled: flag, dma
// - rx flag clear at four or fewer
// - rx interrupt only with rx irq enable
// - idle after three quiet frame times, interrupt
// - idle clear when busy, empty, disabled
// - null char, zero parity, stop: break begin
// - during break store only first null character
// - break then rising receive line: break end
// - break end re-arms break begin, resumes storing
// - error tags in bottom four: flag, block dma
// - no tags left: flag clears, dma resumes
// - break end clears the break interlock
// - writable flags clear by writing one
// - fixed bit positions, bits 6-7 read zero
`timescale 1ns/100ps
`default_nettype none
module uart_status_flags
  import uart_status_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [uart_status_pkg::ADDR_W-1:0] addr,
  input wire logic [uart_status_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [uart_status_pkg::DATA_W-1:0] rdata,
  // transmit side
  input wire logic tx_enable,
  input wire logic [uart_status_pkg::COUNT_W-1:0] tx_fill,
  // receive side
  input wire logic rx_enable,
  input wire logic rx_busy,
  input wire logic [uart_status_pkg::COUNT_W-1:0] rx_fill,
  input wire logic [uart_status_pkg::TAG_W-1:0] rx_err_tags,
  input wire logic frame_tick,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_parity_bit,
  input wire logic rx_stop_bit,
  input wire logic rxd,
  // requests toward the host side
  output logic rx_store,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic irq
);
  import uart_status_pkg::*;

  // ============================================================
  // helpers

  // sticky bit update; a set in the same cycle beats the clear
  function automatic logic [FLAG_W-1:0] sticky(
    input logic [FLAG_W-1:0] cur,
    input logic [FLAG_W-1:0] set,
    input logic [FLAG_W-1:0] clr
  );
    sticky = (cur & ~clr) | set;
  endfunction

  // ============================================================
  // declarations

  // receive pin synchroniser and edge history
  logic rxd_meta; // first stage, read only by rxd_sync
  logic rxd_sync; // safe level of the receive line
  logic rxd_prev; // level one cycle earlier
  // live service and error conditions
  logic tx_service_flag; // transmit service flag
  logic next_tfs;
  logic rx_service_flag; // receive service flag
  logic next_rfs;
  logic fifo_error_flag; // error in fifo flag
  logic next_eif;
  // software-cleared flags and break interlock
  logic idle_flag;
  logic next_idle_flag;
  logic bb_flag; // break begin flag
  logic next_bb_flag;
  logic be_flag; // break end flag
  logic next_be_flag;
  logic interlock; // break seen, waiting for the line to rise
  logic next_interlock;
  // control, interrupt status and mask
  logic [1:0] control; // interrupt enables of the service flags
  logic [1:0] next_control;
  logic [FLAG_W-1:0] irq_status;
  logic [FLAG_W-1:0] next_irq_status;
  logic [FLAG_W-1:0] irq_mask;
  logic [FLAG_W-1:0] next_irq_mask;
  // registered outputs
  logic next_rx_store;
  logic next_tx_dma_req;
  logic next_rx_dma_req;
  logic next_irq;
  logic [DATA_W-1:0] next_rdata;
  // decoded accesses and events
  logic wr_status; // write to the line status register
  logic wr_control;
  logic wr_mask;
  logic rd_irq_status; // read that clears the interrupt status
  logic null_char; // all-zero character with zero parity
  logic break_char; // null character with framing error
  logic bb_set;
  logic be_set;
  logic rx_rise;
  logic [FLAG_W-1:0] events;
  logic [FLAG_W-1:0] line_status; // flags in their register layout

  idle_timer_if idle_link ();

  // ============================================================
  // receive pin synchroniser

  // two stages before anything looks at the asynchronous line
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_prev <= 1'b1;
    end
    else
    begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
      rxd_prev <= rxd_sync;
    end
  end

  // ============================================================
  // idle timer

  assign idle_link.rx_enable = rx_enable;
  assign idle_link.fifo_not_empty = (rx_fill != 4'h0);
  assign idle_link.rx_busy = rx_busy;
  assign idle_link.char_arrived = rx_char_valid;
  assign idle_link.frame_tick = frame_tick;

  rx_idle_timer u_idle (
    .clk (clk),
    .srst (srst),
    .link (idle_link)
  );

  // ============================================================
  // access decode and event detection
  always_comb
  begin
    wr_status = wr && (addr == OFS_LINE_STATUS);
    wr_control = wr && (addr == OFS_CONTROL);
    wr_mask = wr && (addr == OFS_IRQ_MASK);
    rd_irq_status = rd && (addr == OFS_IRQ_STATUS);
    null_char = (rx_char_data == 8'h00) && !rx_parity_bit;
    break_char = null_char && !rx_stop_bit;
    // detection is blocked while the interlock holds
    bb_set = rx_char_valid && break_char && !interlock;
    rx_rise = rxd_sync && !rxd_prev;
    be_set = interlock && rx_rise;
  end

  // ============================================================
  // live service and error flags
  always_comb
  begin
    next_tfs = tx_enable && (tx_fill <= TX_SERVICE_MAX);
    // the overlapping thresholds collapse to five or more
    next_rfs = rx_enable && (rx_fill >= RX_SERVICE_MIN);
    next_eif = |rx_err_tags;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_service_flag <= 1'b0;
      rx_service_flag <= 1'b0;
      fifo_error_flag <= 1'b0;
    end
    else
    begin
      tx_service_flag <= next_tfs;
      rx_service_flag <= next_rfs;
      fifo_error_flag <= next_eif;
    end
  end

  // ============================================================
  // software-cleared flags and the break interlock
  always_comb
  begin
    // write one clears; a same-cycle set still wins
    next_idle_flag = (idle_flag && !(wr_status && wdata[BIT_RX_IDLE]))
      || idle_link.idle_event;
    // idle flag is only valid on an enabled, quiet, non-empty receiver
    if (rx_busy || !rx_enable || (rx_fill == 4'h0))
    begin
      next_idle_flag = 1'b0;
    end
    next_bb_flag = (bb_flag && !(wr_status && wdata[BIT_BREAK_BEGIN])) || bb_set;
    next_be_flag = (be_flag && !(wr_status && wdata[BIT_BREAK_END])) || be_set;
    next_interlock = interlock;
    if (be_set)
    begin
      next_interlock = 1'b0;
    end
    else if (bb_set)
    begin
      next_interlock = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      idle_flag <= 1'b0;
      bb_flag <= 1'b0;
      be_flag <= 1'b0;
      interlock <= 1'b0;
    end
    else
    begin
      idle_flag <= next_idle_flag;
      bb_flag <= next_bb_flag;
      be_flag <= next_be_flag;
      interlock <= next_interlock;
    end
  end

  // ============================================================
  // receive store gate and dma requests
  always_comb
  begin
    // the first break character goes in, later ones are dropped
    next_rx_store = rx_char_valid && !(interlock && break_char);
    next_tx_dma_req = next_tfs;
    // errors near the fifo head hold off the receive dma
    next_rx_dma_req = next_rfs && !next_eif;
  end

  // ============================================================
  // interrupt events, status, mask and output
  always_comb
  begin
    events = '0;
    // service conditions raise interrupts only when enabled
    events[BIT_TX_SERVICE] = next_tfs && control[BIT_TX_IRQ_ENABLE];
    events[BIT_RX_SERVICE] = next_rfs && control[BIT_RX_IRQ_ENABLE];
    events[BIT_RX_IDLE] = idle_link.idle_event;
    events[BIT_BREAK_BEGIN] = bb_set;
    events[BIT_BREAK_END] = be_set;
    events[BIT_FIFO_ERROR] = next_eif;
    next_irq_status = sticky(irq_status, events, rd_irq_status ? {FLAG_W{1'b1}} : '0);
    next_irq_mask = wr_mask ? wdata[FLAG_W-1:0] : irq_mask;
    next_control = wr_control ? wdata[1:0] : control;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // ============================================================
  // register read mux; data stand only in the cycle after the read
  always_comb
  begin
    line_status = '0;
    line_status[BIT_TX_SERVICE] = tx_service_flag;
    line_status[BIT_RX_SERVICE] = rx_service_flag;
    line_status[BIT_RX_IDLE] = idle_flag;
    line_status[BIT_BREAK_BEGIN] = bb_flag;
    line_status[BIT_BREAK_END] = be_flag;
    line_status[BIT_FIFO_ERROR] = fifo_error_flag;
    next_rdata = RDATA_RESET;
    if (rd)
    begin
      case (addr)
        // upper two bits stay zero in every register
        OFS_LINE_STATUS: next_rdata = {2'b00, line_status};
        OFS_CONTROL: next_rdata = {6'b000000, control};
        OFS_IRQ_STATUS: next_rdata = {2'b00, irq_status};
        OFS_IRQ_MASK: next_rdata = {2'b00, irq_mask};
        // unmapped addresses read as zero
        default: next_rdata = RDATA_RESET;
      endcase
    end
  end

  // ============================================================
  // output and control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      control <= CONTROL_RESET;
      irq_status <= FLAGS_RESET;
      irq_mask <= FLAGS_RESET;
      rdata <= RDATA_RESET;
      rx_store <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      control <= next_control;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      rx_store <= next_rx_store;
      tx_dma_req <= next_tx_dma_req;
      rx_dma_req <= next_rx_dma_req;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

// ==== pkg/uart_status_pkg.sv ====
`default_nettype none
// ============================================================
// shared constants of the line status block
package uart_status_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // fifo fill counts and error tags of the four bottom receive entries
  localparam int COUNT_W = 4;
  localparam int TAG_W = 12;
  // register offsets
  localparam logic [7:0] OFS_LINE_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  // status bit positions, shared by the interrupt status and mask registers
  localparam int BIT_TX_SERVICE = 0;
  localparam int BIT_RX_SERVICE = 1;
  localparam int BIT_RX_IDLE = 2;
  localparam int BIT_BREAK_BEGIN = 3;
  localparam int BIT_BREAK_END = 4;
  localparam int BIT_FIFO_ERROR = 5;
  localparam int FLAG_W = 6;
  // control bit positions
  localparam int BIT_TX_IRQ_ENABLE = 0;
  localparam int BIT_RX_IRQ_ENABLE = 1;
  // fill thresholds and idle time in frame times
  localparam logic [3:0] TX_SERVICE_MAX = 4'h4;
  localparam logic [3:0] RX_SERVICE_MIN = 4'h5;
  localparam logic [1:0] IDLE_FRAMES = 2'h3;
  // values after reset
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [1:0] FRAMES_RESET = 2'h0;
endpackage
`default_nettype wire

// ==== pkg/idle_timer_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// link between the flag logic and the idle frame timer
interface idle_timer_if;
  logic rx_enable; // receiver switched on
  logic fifo_not_empty; // receive fifo holds data
  logic rx_busy; // a frame is being shifted in
  logic char_arrived; // one-cycle pulse per received character
  logic frame_tick; // one-cycle pulse per elapsed frame time
  logic idle_event; // one-cycle pulse when the line went idle
  modport timer (
    input rx_enable,
    input fifo_not_empty,
    input rx_busy,
    input char_arrived,
    input frame_tick,
    output idle_event
  );
  modport flags (
    output rx_enable,
    output fifo_not_empty,
    output rx_busy,
    output char_arrived,
    output frame_tick,
    input idle_event
  );
endinterface
`default_nettype wire

// ==== logic/rx_idle_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// counts frame times with no new character and fires once
module rx_idle_timer
  import uart_status_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  idle_timer_if.timer link
);
  logic [1:0] frames; // frame times seen since the last character
  logic [1:0] next_frames;
  logic fired; // event already given for this quiet spell
  logic next_fired;
  logic pulse; // registered idle event
  logic next_pulse;

  // ============================================================
  // next state of the quiet-line counter
  always_comb
  begin
    next_frames = frames;
    next_fired = fired;
    next_pulse = 1'b0;
    if (link.char_arrived || !link.rx_enable || !link.fifo_not_empty)
    begin
      // any new character or an unusable fifo restarts the wait
      next_frames = FRAMES_RESET;
      next_fired = 1'b0;
    end
    else if (frames == IDLE_FRAMES)
    begin
      // fire once; a busy receiver holds the event back
      if (!fired && !link.rx_busy)
      begin
        next_pulse = 1'b1;
        next_fired = 1'b1;
      end
    end
    else if (link.frame_tick)
    begin
      next_frames = frames + 2'h1;
    end
  end

  // ============================================================
  // registers of the counter
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      frames <= FRAMES_RESET;
      fired <= 1'b0;
      pulse <= 1'b0;
    end
    else
    begin
      frames <= next_frames;
      fired <= next_fired;
      pulse <= next_pulse;
    end
  end

  assign link.idle_event = pulse;
endmodule
`default_nettype wire

// ==== test/uart_status_flags_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// port checks of the line status block
module uart_status_flags_checker
  import uart_status_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [uart_status_pkg::ADDR_W-1:0] addr,
  input wire logic rd,
  input wire logic [uart_status_pkg::DATA_W-1:0] rdata,
  input wire logic tx_enable,
  input wire logic [uart_status_pkg::COUNT_W-1:0] tx_fill,
  input wire logic rx_enable,
  input wire logic [uart_status_pkg::COUNT_W-1:0] rx_fill,
  input wire logic [uart_status_pkg::TAG_W-1:0] rx_err_tags,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_parity_bit,
  input wire logic rx_stop_bit,
  input wire logic rxd,
  input wire logic rx_store,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req
);
  // null character with zero parity and stop, the start of a break
  wire null_c = rx_char_valid && rx_char_data == 8'h00 && !rx_parity_bit && !rx_stop_bit;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_tx_dma_level: assert property (!$past(srst) |->
    tx_dma_req == $past(tx_enable && tx_fill <= TX_SERVICE_MAX)) else $error("tx dma wrong");
  a_rx_dma_gate: assert property (!$past(srst) |-> rx_dma_req ==
    $past(rx_enable && rx_fill >= RX_SERVICE_MIN && rx_err_tags == '0)) else $error("rx dma");
  a_store_cause: assert property (rx_store |-> $past(rx_char_valid))
    else $error("store without char");
  a_store_plain: assert property (rx_char_valid && rx_char_data != 8'h00 |=> rx_store)
    else $error("data char lost");
  // the line stays low between two nulls, so the second one is dropped
  a_break_once: assert property ((!rxd throughout (null_c ##[1:50] null_c)) |=> !rx_store)
    else $error("second null stored");
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata outside read");
  a_rsvd_zero: assert property ($past(rd) |-> rdata[7:6] == 2'b00)
    else $error("reserved bits set");
  a_eif_read: assert property (rd && addr == OFS_LINE_STATUS && $stable(rx_err_tags) |=>
    rdata[BIT_FIFO_ERROR] == $past(|rx_err_tags)) else $error("error flag wrong");
endmodule
bind uart_status_flags uart_status_flags_checker u_chk (.clk, .srst, .addr, .rd, .rdata,
  .tx_enable, .tx_fill, .rx_enable, .rx_fill, .rx_err_tags, .rx_char_valid, .rx_char_data,
  .rx_parity_bit, .rx_stop_bit, .rxd, .rx_store, .tx_dma_req, .rx_dma_req);
`default_nettype wire

// ==== test/remote_serial_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// far transmitter: command 1 data char, 2 null char, 3 line back high
module remote_serial_model
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] cmd,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic rx_parity_bit,
  output logic rx_stop_bit,
  output logic rxd,
  output logic frame_tick
);
  logic [1:0] tick_cnt; // clocks within one short frame time
  // character fields toggle outside valid so stale values never pass
  always_ff @(posedge clk)
  begin
    tick_cnt <= srst ? 2'h0 : tick_cnt + 2'h1;
    frame_tick <= !srst && tick_cnt == 2'h3;
    rx_char_valid <= !srst && (cmd == 2'h1 || cmd == 2'h2);
    rx_char_data <= (cmd == 2'h1) ? 8'h5a : (cmd == 2'h2) ? 8'h00 : ~rx_char_data;
    rx_parity_bit <= (cmd == 2'h1) ? 1'b1 : (cmd == 2'h2) ? 1'b0 : ~rx_parity_bit;
    rx_stop_bit <= (cmd == 2'h1) ? 1'b1 : (cmd == 2'h2) ? 1'b0 : ~rx_stop_bit;
    // a break holds the line low until released
    rxd <= srst ? 1'b1 : (cmd == 2'h2) ? 1'b0 : (cmd[0] ? 1'b1 : rxd);
  end
endmodule
`default_nettype wire

// ==== test/uart_status_flags_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// register sequences with expected values
module uart_status_flags_tb_top;
  import uart_status_pkg::*;
  logic clk, srst, wr, rd, tx_enable, rx_enable, rx_busy, rx_store, tx_dma_req, rx_dma_req, irq;
  logic rx_char_valid, rx_parity_bit, rx_stop_bit, rxd, frame_tick;
  logic [7:0] addr, wdata, rdata, rx_char_data, v;
  logic [3:0] tx_fill, rx_fill;
  logic [11:0] rx_err_tags;
  logic [1:0] cmd;
  logic [7:0] offs [5] = '{OFS_LINE_STATUS, OFS_CONTROL, OFS_IRQ_STATUS, OFS_IRQ_MASK, 8'h10};
  int bad_count, checks_done, cycles, store_cnt, c0;
  uart_status_flags u_uart_status_flags (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
    .tx_enable, .tx_fill, .rx_enable, .rx_busy, .rx_fill, .rx_err_tags, .frame_tick,
    .rx_char_valid, .rx_char_data, .rx_parity_bit, .rx_stop_bit, .rxd, .rx_store,
    .tx_dma_req, .rx_dma_req, .irq);
  remote_serial_model u_remote_serial_model (.clk, .srst, .cmd, .rx_char_valid,
    .rx_char_data, .rx_parity_bit, .rx_stop_bit, .rxd, .frame_tick);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ============================================================
  // pulse count and hang guard
  always @(posedge clk)
  begin
    store_cnt += (rx_store === 1'b1);
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end
  // wide enough for an output bit beside a full register value
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    // outputs launched by this edge are only settled a little later
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic send(input logic [1:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 2'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ============================================================
  // main sequence
  initial
  begin
    // a busy receiver keeps the idle timer quiet until the idle scenarios
    {srst, wr, rd, tx_enable, rx_enable, rx_busy, addr, wdata} = {1'b1, 4'h0, 1'b1, 16'h0000};
    {tx_fill, rx_fill, rx_err_tags, cmd} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    foreach (offs[i])
    begin
      rd_reg(offs[i]);
      check("reset value", v, 8'h00);
    end
    wr_reg(OFS_LINE_STATUS, 8'hff);
    rd_reg(OFS_LINE_STATUS);
    check("ignored write", v, 8'h00);
    tx_enable <= 1'b1;
    rx_enable <= 1'b1;
    for (int f = 0; f < 16; f++)
    begin
      tx_fill <= 4'(f);
      rx_fill <= 4'(f);
      rd_reg(OFS_LINE_STATUS);
      check("service bits", v, {f >= 5, f <= 4});
      check("tx dma", tx_dma_req, f <= 4);
      check("rx dma", rx_dma_req, f >= 5);
    end
    {tx_enable, rx_enable, tx_fill, rx_fill} <= {2'b00, 4'h2, 4'h6};
    rd_reg(OFS_LINE_STATUS);
    check("disabled", {v[1:0], tx_dma_req, rx_dma_req}, 8'h0);
    rx_enable <= 1'b1;
    for (int b = 0; b < 12; b++)
    begin
      rx_err_tags <= 12'h1 << b;
      rd_reg(OFS_LINE_STATUS);
      check("tag blocks dma", {v[BIT_FIFO_ERROR], rx_dma_req}, 8'h2);
    end
    rx_err_tags <= '0;
    rd_reg(OFS_LINE_STATUS);
    check("tags gone", {v[BIT_FIFO_ERROR], rx_dma_req}, 8'h1);
    {tx_enable, tx_fill, rx_fill} <= {1'b1, 4'h2, 4'h0};
    wr_reg(OFS_IRQ_MASK, 8'h01);
    rd_reg(OFS_IRQ_STATUS);
    check("tx irq off", {irq, tx_dma_req}, 8'h1);
    wr_reg(OFS_CONTROL, 8'h01);
    rd_reg(OFS_IRQ_STATUS);
    check("tx irq status", {irq, v}, 9'h101);
    wr_reg(OFS_IRQ_MASK, 8'h00);
    check("masked irq", irq, 1'b0);
    {tx_enable, rx_fill} <= {1'b0, 4'h6};
    wr_reg(OFS_CONTROL, 8'h02);
    wr_reg(OFS_IRQ_MASK, 8'h22);
    check("rx irq", irq, 1'b1);
    wr_reg(OFS_CONTROL, 8'h00);
    rx_err_tags <= 12'h400;
    rd_reg(OFS_IRQ_STATUS);
    check("error irq", irq, 1'b1);
    rx_err_tags <= '0;
    rd_reg(OFS_IRQ_STATUS);
    rd_reg(OFS_IRQ_STATUS);
    check("irq cleared", {irq, v}, 9'h0);
    rx_fill <= 4'h1;
    wr_reg(OFS_IRQ_MASK, 8'h18);
    c0 = store_cnt;
    send(2'h2);
    send(2'h2);
    check("one null stored", 8'(store_cnt - c0), 8'h1);
    rd_reg(OFS_LINE_STATUS);
    check("break begin", {irq, v[BIT_BREAK_BEGIN]}, 8'h3);
    send(2'h3);
    rd_reg(OFS_LINE_STATUS);
    check("break end", v[BIT_BREAK_END], 1'b1);
    send(2'h2);
    check("storing again", 8'(store_cnt - c0), 8'h2);
    wr_reg(OFS_LINE_STATUS, 8'h18);
    rd_reg(OFS_LINE_STATUS);
    check("w1c break", v[4:3], 8'h0);
    // the last character is long past, so releasing busy fires the idle event
    rx_busy <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(OFS_LINE_STATUS);
    check("idle on release", v[BIT_RX_IDLE], 1'b1);
    wr_reg(OFS_LINE_STATUS, 8'h04);
    rd_reg(OFS_LINE_STATUS);
    check("idle cleared", v[BIT_RX_IDLE], 1'b0);
    send(2'h1);
    repeat (20) @(posedge clk);
    rd_reg(OFS_LINE_STATUS);
    check("idle set", v[BIT_RX_IDLE], 1'b1);
    wr_reg(OFS_LINE_STATUS, 8'h04);
    rx_busy <= 1'b1;
    send(2'h1);
    repeat (20) @(posedge clk);
    rd_reg(OFS_LINE_STATUS);
    check("idle while busy", v[BIT_RX_IDLE], 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
